// *** uce0_pkg.sv ***
// Package for the endpoint-zero control block: register map, fields, link codes
package uce0_pkg;
  // APB register offsets (byte addresses, one aligned word each except the sixteen-word data buffer)
  localparam logic [7:0] UCE0_OFF_IRQ_REQ = 8'h00; // usb_irq_request_reg
  localparam logic [7:0] UCE0_OFF_IRQ_EN = 8'h04; // usb_irq_enable_reg
  localparam logic [7:0] UCE0_OFF_CS = 8'h08; // Stall and handshake hold
  localparam logic [7:0] UCE0_OFF_BCNT = 8'h0c; // control_byte_count
  localparam logic [7:0] UCE0_OFF_SUDPTR = 8'h10; // setup_data_pointer
  localparam logic [7:0] UCE0_OFF_FUNCTION_ADDRESS_REG = 8'h14; // function_address_reg
  localparam logic [7:0] UCE0_OFF_CFG = 8'h18; // firmware_owns_requests
  localparam logic [7:0] UCE0_OFF_SETUP0 = 8'h20; // setup_packet_buffer bytes 0..3
  localparam logic [7:0] UCE0_OFF_SETUP1 = 8'h24; // setup_packet_buffer bytes 4..7
  localparam logic [7:0] UCE0_OFF_DBUF = 8'h40; // control_data_buffer words 0x40..0x7c
  // Field positions
  localparam int UCE0_IRQ_SETUP_TOKEN_IRQ_BIT = 0;
  localparam int UCE0_IRQ_SETUP_DATA_IRQ_BIT = 1;
  localparam int UCE0_CS_STALL_BIT = 0;
  localparam int UCE0_CS_HOLD_BIT = 1;
  localparam int UCE0_CS_BUSY_BIT = 2;
  // Sizes
  localparam int UCE0_DBUF_BYTES = 64;
  localparam int UCE0_SETUP_BYTES = 8;
  localparam logic [7:0] UCE0_REQ_SET_ADDRESS = 8'h05;
  localparam logic [6:0] UCE0_FUNCTION_ADDRESS_REG_RST = 7'h00;
  localparam int UCE0_HOST_WAIT = 8; // Host gives up on an answer after this many idle cycles
  // Token kinds on the link
  typedef enum logic [1:0] {
    UCE0_TOK_SETUP = 2'b00,
    UCE0_TOK_OUT = 2'b01,
    UCE0_TOK_IN = 2'b10
  } uce0_tok_t;
  // Handshake answers
  typedef enum logic [1:0] {
    UCE0_HS_ACK = 2'b00,
    UCE0_HS_NAK = 2'b01,
    UCE0_HS_STALL = 2'b10
  } uce0_hs_t;
endpackage : uce0_pkg

// *** uce0_link_if.sv ***
// Interface joining host end and device end of the control endpoint link
`timescale 1ns/100ps
`default_nettype none
interface uce0_link_if;
  import uce0_pkg::*;
  logic tok_valid; // Host: one-cycle token strobe
  uce0_tok_t tok_kind; // Host: token kind
  logic [3:0] tok_ep; // Host: endpoint number
  logic dat_valid; // Host: one-cycle data byte strobe
  logic [7:0] dat_byte; // Host data byte
  logic dat_last; // Host: last byte of packet
  logic dat_crc_ok; // Host: packet checked good, with dat_last
  logic [7:0] dev_byte; // Device IN data byte
  logic dev_valid; // Device IN byte strobe
  logic dev_last; // Device last IN byte (or zero-length marker)
  logic hs_valid; // Device: one-cycle handshake strobe
  uce0_hs_t hs_code; // Device handshake answer
  modport host (output tok_valid, tok_kind, tok_ep, dat_valid, dat_byte, dat_last, dat_crc_ok,
    input dev_byte, dev_valid, dev_last, hs_valid, hs_code);
  modport dev (input tok_valid, tok_kind, tok_ep, dat_valid, dat_byte, dat_last, dat_crc_ok,
    output dev_byte, dev_valid, dev_last, hs_valid, hs_code);
endinterface : uce0_link_if
`default_nettype wire

// *** uce0_device.sv ***
// Device end: endpoint zero control logic with APB register slave
// Summary of operation
// - Only endpoint zero takes SETUP tokens.
// - Endpoint zero is always enabled.
// - One 64-byte buffer serves IN and OUT.
// - SETUP payload goes to 8-byte setup buffer.
// - SETUP bytes never enter the data buffer.
// - Data stage ACKed only after byte count loaded.
// - Status stage is opposite-direction zero-length packet.
// - Hold bit set means NAK status stage.
// - Hold bit cleared by writing one.
// - Stall needs stall and hold bits; never SETUP.
// - Next SETUP token clears stall bit.
// - Firmware arms data only for nonzero length.
// - SETUP token sets setup-token request.
// - Good eight bytes set setup-data request, unless hardware takes set-address.
// - Requests sticky until write-one, ignore enables.
// - Always accept SETUP, overwrite setup buffer.
// - Enable bits gate the two setup interrupts.
// - Sixteen-bit setup data pointer provided.
// - Hardware performs set-address, others to firmware.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module uce0_device (
  input wire logic clk_i,
  input wire logic rst_b_i,
  uce0_link_if.dev link,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic [6:0] fn_addr_o
);
  import uce0_pkg::*;
  // Storage
  logic [7:0] dbuf_mem [UCE0_DBUF_BYTES]; // Shared IN/OUT data buffer
  logic [7:0] setup_mem [UCE0_SETUP_BYTES]; // Setup packet buffer
  logic [7:0] setup_tmp [UCE0_SETUP_BYTES]; // Staging so a bad packet never lands
  // Control state
  logic [1:0] irq_req_reg; // Sticky setup requests
  logic [1:0] irq_en_reg; // Interrupt enables
  logic stall_reg; // Endpoint zero stall bit
  logic hold_reg; // handshake_hold_bit
  logic armed_reg; // Byte count loaded, data stage armed
  logic [6:0] bcnt_reg; // control_byte_count
  logic [15:0] sudptr_reg; // setup_data_pointer
  logic [6:0] function_address_reg_reg; // function_address_reg
  logic fw_owns_reg; // firmware_owns_requests
  logic [2:0] sidx_reg; // Setup byte index
  logic [5:0] didx_reg; // Data byte index
  logic in_setup_reg; // SETUP data packet expected
  logic in_out_reg; // OUT data packet in progress
  logic in_send_reg; // IN packet being sent
  logic [6:0] send_left_reg; // Bytes left to send
  logic [7:0] dev_byte_reg;
  logic dev_valid_reg;
  logic dev_last_reg;
  logic hs_valid_reg;
  uce0_hs_t hs_code_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg; // Error answer, decided in the setup cycle
  logic irq_reg;
  // APB decode
  wire apb_acc = psel_i && penable_i;
  wire apb_wr = apb_acc && pwrite_i;
  wire hit_dbuf = paddr_i[7:6] == UCE0_OFF_DBUF[7:6];
  wire [5:0] dbuf_word = {paddr_i[5:2], 2'b00};
  wire wr_irq = apb_wr && paddr_i == UCE0_OFF_IRQ_REQ;
  wire wr_en = apb_wr && paddr_i == UCE0_OFF_IRQ_EN;
  wire wr_cs = apb_wr && paddr_i == UCE0_OFF_CS;
  wire wr_bcnt = apb_wr && paddr_i == UCE0_OFF_BCNT;
  wire wr_ptr = apb_wr && paddr_i == UCE0_OFF_SUDPTR;
  wire wr_cfg = apb_wr && paddr_i == UCE0_OFF_CFG;
  wire wr_dbuf = apb_wr && hit_dbuf;
  wire mapped = hit_dbuf || paddr_i inside {UCE0_OFF_IRQ_REQ, UCE0_OFF_IRQ_EN, UCE0_OFF_CS,
    UCE0_OFF_BCNT, UCE0_OFF_SUDPTR, UCE0_OFF_FUNCTION_ADDRESS_REG, UCE0_OFF_CFG, UCE0_OFF_SETUP0,
    UCE0_OFF_SETUP1};
  // Link decode: only endpoint zero exists, so other endpoints are ignored
  wire tok_ep0 = link.tok_valid && link.tok_ep == 4'h0;
  wire tok_setup = tok_ep0 && link.tok_kind == UCE0_TOK_SETUP;
  wire tok_out = tok_ep0 && link.tok_kind == UCE0_TOK_OUT;
  wire tok_in = tok_ep0 && link.tok_kind == UCE0_TOK_IN;
  wire pkt_end = link.dat_valid && link.dat_last;
  wire setup_good = in_setup_reg && pkt_end && link.dat_crc_ok && sidx_reg == 3'h7;
  wire out_good = in_out_reg && pkt_end && link.dat_crc_ok;
  // Stall only counts with the hold bit also set
  wire stall_eff = stall_reg && hold_reg;
  // Hardware set-address when firmware owns requests
  wire is_set_addr = fw_owns_reg && setup_tmp[1] == UCE0_REQ_SET_ADDRESS;
  // A data stage token is one met while armed; otherwise it is a status stage
  wire out_is_status = !armed_reg;
  // SETUP bytes write only staging, never the data buffer
  // Unarmed or stalled OUT data is refused, so it must not touch the buffer
  wire out_dat_wr = in_out_reg && !in_setup_reg && link.dat_valid && armed_reg && !stall_eff;
  wire in_sending = in_send_reg && send_left_reg != 7'h00;
  // Last IN byte or the empty packet is going out this cycle
  wire in_finish = in_send_reg && send_left_reg <= 7'h01;

  // Staging and setup buffer: overwritten by every good SETUP
  always_ff @(posedge clk_i)
  begin
    if (in_setup_reg && link.dat_valid)
      setup_tmp[sidx_reg] <= link.dat_byte;
    if (setup_good)
    begin
      for (int i = 0; i < UCE0_SETUP_BYTES - 1; i++)
        setup_mem[i] <= setup_tmp[i];
      setup_mem[UCE0_SETUP_BYTES - 1] <= link.dat_byte;
    end
  end

  // Data buffer: OUT data from link, IN data from APB words
  always_ff @(posedge clk_i)
  begin
    if (out_dat_wr)
      dbuf_mem[didx_reg] <= link.dat_byte;
    else if (wr_dbuf)
      for (int b = 0; b < 4; b++)
        dbuf_mem[dbuf_word + 6'(b)] <= pwdata_i[8*b +: 8];
  end

  // Sticky requests; a hardware set wins over a write-one clear
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      irq_req_reg <= 2'b00;
    else
    begin
      irq_req_reg[UCE0_IRQ_SETUP_TOKEN_IRQ_BIT] <= tok_setup ||
        (irq_req_reg[UCE0_IRQ_SETUP_TOKEN_IRQ_BIT] && !(wr_irq && pwdata_i[UCE0_IRQ_SETUP_TOKEN_IRQ_BIT]));
      irq_req_reg[UCE0_IRQ_SETUP_DATA_IRQ_BIT] <= (setup_good && !is_set_addr) ||
        (irq_req_reg[UCE0_IRQ_SETUP_DATA_IRQ_BIT] && !(wr_irq && pwdata_i[UCE0_IRQ_SETUP_DATA_IRQ_BIT]));
    end
  end

  // Enables gate the single interrupt output
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      irq_en_reg <= 2'b00;
      irq_reg <= 1'b0;
    end
    else
    begin
      if (wr_en)
        irq_en_reg <= pwdata_i[1:0];
      irq_reg <= |(irq_req_reg & irq_en_reg);
    end
  end

  // Stall and hold bits
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      stall_reg <= 1'b0;
      hold_reg <= 1'b0;
    end
    else
    begin
      if (tok_setup)
        stall_reg <= 1'b0;
      else if (wr_cs)
        stall_reg <= pwdata_i[UCE0_CS_STALL_BIT];
      if (setup_good)
        hold_reg <= 1'b1;
      else if (wr_cs && pwdata_i[UCE0_CS_HOLD_BIT])
        hold_reg <= 1'b0;
    end
  end

  // Byte count arms the data stage; a SETUP or finished data packet disarms
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      armed_reg <= 1'b0;
      bcnt_reg <= 7'h00;
    end
    else if (tok_setup)
      armed_reg <= 1'b0;
    else if (wr_bcnt)
    begin
      armed_reg <= 1'b1;
      bcnt_reg <= (pwdata_i[6:0] > 7'(UCE0_DBUF_BYTES)) ? 7'(UCE0_DBUF_BYTES) : pwdata_i[6:0];
    end
    else if ((out_good || in_finish) && armed_reg)
    begin
      armed_reg <= 1'b0;
      bcnt_reg <= out_good ? {1'b0, didx_reg} + 7'h01 : bcnt_reg;
    end
  end

  // Pointer, address and configuration registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sudptr_reg <= 16'h0000;
      function_address_reg_reg <= UCE0_FUNCTION_ADDRESS_REG_RST;
      fw_owns_reg <= 1'b0;
    end
    else
    begin
      if (wr_ptr)
        sudptr_reg <= pwdata_i[15:0];
      if (wr_cfg)
        fw_owns_reg <= pwdata_i[0];
      if (setup_good && is_set_addr)
        function_address_reg_reg <= setup_tmp[2][6:0];
    end
  end

  // Packet reception tracking and handshakes
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      in_setup_reg <= 1'b0;
      in_out_reg <= 1'b0;
      sidx_reg <= 3'h0;
      didx_reg <= 6'h00;
      hs_valid_reg <= 1'b0;
      hs_code_reg <= UCE0_HS_ACK;
    end
    else
    begin
      hs_valid_reg <= 1'b0;
      if (tok_setup)
      begin
        in_setup_reg <= 1'b1; // SETUP is never NAKed or stalled
        in_out_reg <= 1'b0;
        sidx_reg <= 3'h0;
      end
      else if (tok_out)
      begin
        in_out_reg <= 1'b1;
        didx_reg <= 6'h00;
      end
      if (in_setup_reg && link.dat_valid)
      begin
        sidx_reg <= sidx_reg + 3'h1;
        if (link.dat_last)
        begin
          in_setup_reg <= 1'b0;
          // Bad or short packets get no answer, so the host retries
          hs_valid_reg <= setup_good;
          hs_code_reg <= UCE0_HS_ACK;
        end
      end
      else if (out_dat_wr)
        didx_reg <= didx_reg + 6'h01;
      if (in_out_reg && pkt_end)
      begin
        in_out_reg <= 1'b0;
        hs_valid_reg <= link.dat_crc_ok;
        if (stall_eff)
          hs_code_reg <= UCE0_HS_STALL;
        else if (out_is_status ? hold_reg : !armed_reg)
          hs_code_reg <= UCE0_HS_NAK;
        else
          hs_code_reg <= UCE0_HS_ACK;
      end
      if (tok_in && (stall_eff || (!armed_reg && hold_reg)))
      begin
        hs_valid_reg <= 1'b1;
        hs_code_reg <= stall_eff ? UCE0_HS_STALL : UCE0_HS_NAK;
      end
    end
  end

  // IN packet sender: data stage when armed, zero-length status otherwise
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      in_send_reg <= 1'b0;
      send_left_reg <= 7'h00;
      dev_valid_reg <= 1'b0;
      dev_last_reg <= 1'b0;
      dev_byte_reg <= 8'h00;
    end
    else
    begin
      dev_valid_reg <= 1'b0;
      dev_last_reg <= 1'b0;
      if (tok_in && !stall_eff && (armed_reg || !hold_reg))
      begin
        in_send_reg <= 1'b1;
        send_left_reg <= armed_reg ? bcnt_reg : 7'h00;
      end
      else if (in_sending)
      begin
        dev_valid_reg <= 1'b1;
        dev_byte_reg <= dbuf_mem[6'(bcnt_reg - send_left_reg)];
        dev_last_reg <= send_left_reg == 7'h01;
        send_left_reg <= send_left_reg - 7'h01;
        in_send_reg <= send_left_reg != 7'h01;
      end
      else if (in_send_reg)
      begin
        // Zero-length packet: a lone last marker with no valid
        dev_last_reg <= 1'b1;
        in_send_reg <= 1'b0;
      end
    end
  end

  // APB read data and answer: zero wait states
  wire [7:0] dbyte0 = dbuf_mem[dbuf_word];
  wire [7:0] dbyte1 = dbuf_mem[dbuf_word + 6'h01];
  wire [7:0] dbyte2 = dbuf_mem[dbuf_word + 6'h02];
  wire [7:0] dbyte3 = dbuf_mem[dbuf_word + 6'h03];
  wire [31:0] rd_mux =
    hit_dbuf ? {dbyte3, dbyte2, dbyte1, dbyte0} :
    paddr_i == UCE0_OFF_IRQ_REQ ? {30'h0, irq_req_reg} :
    paddr_i == UCE0_OFF_IRQ_EN ? {30'h0, irq_en_reg} :
    paddr_i == UCE0_OFF_CS ? {29'h0, armed_reg, hold_reg, stall_reg} :
    paddr_i == UCE0_OFF_BCNT ? {25'h0, bcnt_reg} :
    paddr_i == UCE0_OFF_SUDPTR ? {16'h0, sudptr_reg} :
    paddr_i == UCE0_OFF_FUNCTION_ADDRESS_REG ? {25'h0, function_address_reg_reg} :
    paddr_i == UCE0_OFF_CFG ? {31'h0, fw_owns_reg} :
    paddr_i == UCE0_OFF_SETUP0 ? {setup_mem[3], setup_mem[2], setup_mem[1], setup_mem[0]} :
    paddr_i == UCE0_OFF_SETUP1 ? {setup_mem[7], setup_mem[6], setup_mem[5], setup_mem[4]} :
    32'h0000_0000;

  // Read data registered in the setup cycle so it stands during access
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      prdata_reg <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i)
      prdata_reg <= rd_mux;
  end

  // Error answer registered too, so the output comes straight from a flop
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      pslverr_reg <= 1'b0;
    else
      pslverr_reg <= psel_i && !penable_i && !mapped;
  end

  assign prdata_o = prdata_reg;
  assign pready_o = 1'b1;
  assign pslverr_o = pslverr_reg;
  assign irq_o = irq_reg;
  assign fn_addr_o = function_address_reg_reg;
  assign link.dev_byte = dev_byte_reg;
  assign link.dev_valid = dev_valid_reg;
  assign link.dev_last = dev_last_reg;
  assign link.hs_valid = hs_valid_reg;
  assign link.hs_code = hs_code_reg;
endmodule : uce0_device
`default_nettype wire

// *** uce0_host.sv ***
// Host end: issues control transfer tokens and packets on the link
`timescale 1ns/100ps
`default_nettype none
module uce0_host (
  input wire logic clk_i,
  input wire logic rst_b_i,
  uce0_link_if.host link,
  input wire logic cmd_valid_i,
  input wire uce0_pkg::uce0_tok_t cmd_kind_i,
  input wire logic [3:0] cmd_ep_i,
  input wire logic [63:0] cmd_data_i,
  input wire logic [3:0] cmd_len_i,
  input wire logic cmd_bad_crc_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output uce0_pkg::uce0_hs_t rsp_hs_o,
  output logic [7:0] rsp_byte_o,
  output logic rsp_byte_valid_o,
  output logic rsp_last_o
);
  import uce0_pkg::*;
  typedef enum logic [1:0] {
    UCE0H_IDLE = 2'b00,
    UCE0H_DATA = 2'b01,
    UCE0H_WAIT = 2'b10
  } uce0h_state_t;
  uce0h_state_t state_reg; // Sequencer state
  logic [63:0] data_reg; // Bytes to send, byte 0 low
  logic [3:0] left_reg; // Bytes left
  logic bad_reg; // Inject a bad CRC on this packet
  logic [3:0] wait_reg; // Cycles spent waiting with no answer
  logic tv_reg;
  uce0_tok_t tk_reg;
  logic [3:0] te_reg;
  logic dv_reg;
  logic [7:0] db_reg;
  logic dl_reg;
  logic dc_reg;
  logic rv_reg;
  uce0_hs_t rh_reg;
  logic bv_reg;
  logic [7:0] bb_reg;
  logic bl_reg;

  // Sequencer: token, then data bytes (SETUP/OUT), then wait for an answer
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= UCE0H_IDLE;
      tv_reg <= 1'b0;
      tk_reg <= UCE0_TOK_SETUP;
      te_reg <= 4'h0;
      dv_reg <= 1'b0;
      db_reg <= 8'h00;
      dl_reg <= 1'b0;
      dc_reg <= 1'b0;
      data_reg <= 64'h0;
      left_reg <= 4'h0;
      bad_reg <= 1'b0;
      wait_reg <= 4'h0;
    end
    else
    begin
      tv_reg <= 1'b0;
      dv_reg <= 1'b0;
      dl_reg <= 1'b0;
      unique case (state_reg)
        UCE0H_IDLE:
          if (cmd_valid_i)
          begin
            tv_reg <= 1'b1;
            tk_reg <= cmd_kind_i;
            te_reg <= cmd_ep_i;
            data_reg <= cmd_data_i;
            left_reg <= cmd_len_i;
            bad_reg <= cmd_bad_crc_i;
            wait_reg <= 4'h0;
            state_reg <= (cmd_kind_i == UCE0_TOK_IN) ? UCE0H_WAIT : UCE0H_DATA;
          end
        UCE0H_DATA:
          begin
            // A zero-length OUT is sent as one marker byte flagged last
            dv_reg <= 1'b1;
            db_reg <= data_reg[7:0];
            data_reg <= {8'h00, data_reg[63:8]};
            dl_reg <= left_reg <= 4'h1;
            dc_reg <= !bad_reg;
            left_reg <= left_reg - 4'h1;
            if (left_reg <= 4'h1)
              state_reg <= UCE0H_WAIT;
          end
        UCE0H_WAIT:
          begin
            // A token for an absent endpoint gets no answer, so give up after a while
            wait_reg <= link.dev_valid ? 4'h0 : wait_reg + 4'h1;
            if (link.hs_valid || (link.dev_last && !link.dev_valid) ||
                (link.dev_valid && link.dev_last) || (dl_reg && !dc_reg) ||
                wait_reg == 4'(UCE0_HOST_WAIT))
              state_reg <= UCE0H_IDLE;
          end
      endcase
    end
  end

  // Answer capture from the device
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      rv_reg <= 1'b0;
      rh_reg <= UCE0_HS_ACK;
      bv_reg <= 1'b0;
      bb_reg <= 8'h00;
      bl_reg <= 1'b0;
    end
    else
    begin
      rv_reg <= link.hs_valid;
      rh_reg <= link.hs_code;
      bv_reg <= link.dev_valid;
      bb_reg <= link.dev_byte;
      bl_reg <= link.dev_last;
    end
  end

  assign cmd_ready_o = state_reg == UCE0H_IDLE;
  assign link.tok_valid = tv_reg;
  assign link.tok_kind = tk_reg;
  assign link.tok_ep = te_reg;
  assign link.dat_valid = dv_reg;
  assign link.dat_byte = db_reg;
  assign link.dat_last = dl_reg;
  assign link.dat_crc_ok = dc_reg;
  assign rsp_valid_o = rv_reg;
  assign rsp_hs_o = rh_reg;
  assign rsp_byte_o = bb_reg;
  assign rsp_byte_valid_o = bv_reg;
  assign rsp_last_o = bl_reg;
endmodule : uce0_host
`default_nettype wire

// *** uce0_link_asserts.sv ***
// Link checker for the endpoint-zero control block
`timescale 1ns/100ps
`default_nettype none
module uce0_link_asserts (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic tok_valid,
  input wire uce0_pkg::uce0_tok_t tok_kind,
  input wire logic [3:0] tok_ep,
  input wire logic dat_valid,
  input wire logic dat_last,
  input wire logic dat_crc_ok,
  input wire logic dev_valid,
  input wire logic dev_last,
  input wire logic hs_valid,
  input wire uce0_pkg::uce0_hs_t hs_code
);
  import uce0_pkg::*;
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Tokens aimed at endpoint zero
  sequence s_su;
    tok_valid && tok_kind == UCE0_TOK_SETUP && tok_ep == 4'h0;
  endsequence
  sequence s_in;
    tok_valid && tok_kind == UCE0_TOK_IN && tok_ep == 4'h0;
  endsequence
  // Whole SETUP packet: eight bytes, good check on the last
  sequence s_su_good;
    s_su ##1 (dat_valid && !dat_last) [*7] ##1 (dat_valid && dat_last && dat_crc_ok);
  endsequence
  chk_setup_acked: assert property (
    s_su_good |=> hs_valid && hs_code == UCE0_HS_ACK)
    else $error("setup packet not acknowledged");
  // No answer may come before all eight bytes are in
  chk_setup_quiet: assert property (
    s_su |=> !hs_valid [*8])
    else $error("handshake inside setup packet");
  chk_bad_silent: assert property (
    dat_valid && dat_last && !dat_crc_ok |=> !hs_valid)
    else $error("handshake after bad packet");
  // IN is answered by NAK or STALL one cycle on, or by data two cycles on
  chk_in_answered: assert property (
    s_in |-> (##1 hs_valid && hs_code != UCE0_HS_ACK) or (##2 dev_valid || dev_last))
    else $error("IN token not answered in time");
  chk_other_ep: assert property (
    tok_valid && tok_ep != 4'h0 |=> !hs_valid ##1 !(dev_valid || dev_last))
    else $error("other endpoint answered");
  chk_hs_caused: assert property (
    hs_valid |-> $past(dat_last) || $past(tok_valid && tok_kind != UCE0_TOK_SETUP))
    else $error("handshake without cause");
  chk_hs_strobe: assert property (
    hs_valid |=> !hs_valid)
    else $error("handshake longer than one cycle");
  chk_zlp_timing: assert property (
    dev_last && !dev_valid |-> $past(tok_valid && tok_kind == UCE0_TOK_IN, 2))
    else $error("empty IN packet out of place");
endmodule : uce0_link_asserts
`default_nettype wire

// *** tb.sv ***
// Testbench: host end and device end joined, driven over APB and commands
`timescale 1ns/100ps
`default_nettype none
module tb;
  import uce0_pkg::*;
  localparam logic [31:0] NONE = 32'hff; // No handshake expected
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [6:0] fn_addr;
  logic cmd_valid = 1'b0;
  uce0_tok_t cmd_kind = UCE0_TOK_SETUP;
  logic [3:0] cmd_ep = 4'h0;
  logic [63:0] cmd_data = 64'h0;
  logic [3:0] cmd_len = 4'h0;
  logic cmd_bad = 1'b0;
  logic cmd_ready;
  logic rsp_valid;
  uce0_hs_t rsp_hs;
  logic [7:0] rsp_byte;
  logic rsp_bv;
  logic rsp_last;
  logic [31:0] rd; // Last read data
  logic perr; // Last error flag
  logic [31:0] seed = 32'h40fd;
  logic [31:0] hs_q[$]; // Expected handshakes
  logic [31:0] byte_q[$]; // Expected IN bytes
  int failures = 0;
  int n_checks = 0;
  uce0_link_if link ();
  uce0_device uce0_device_inst (.clk_i(clk), .rst_b_i(rst_b), .link(link),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .irq_o(irq), .fn_addr_o(fn_addr));
  uce0_host uce0_host_inst (.clk_i(clk), .rst_b_i(rst_b), .link(link),
    .cmd_valid_i(cmd_valid), .cmd_kind_i(cmd_kind), .cmd_ep_i(cmd_ep),
    .cmd_data_i(cmd_data), .cmd_len_i(cmd_len), .cmd_bad_crc_i(cmd_bad),
    .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_hs_o(rsp_hs),
    .rsp_byte_o(rsp_byte), .rsp_byte_valid_o(rsp_bv), .rsp_last_o(rsp_last));
  uce0_link_asserts uce0_link_asserts_inst (.clk_i(clk), .rst_b_i(rst_b),
    .tok_valid(link.tok_valid), .tok_kind(link.tok_kind), .tok_ep(link.tok_ep),
    .dat_valid(link.dat_valid), .dat_last(link.dat_last),
    .dat_crc_ok(link.dat_crc_ok), .dev_valid(link.dev_valid),
    .dev_last(link.dev_last), .hs_valid(link.hs_valid), .hs_code(link.hs_code));
  always #2.5 clk = ~clk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 50)
    begin
      failures++;
      results();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle cycle, so the next setup never reassigns psel in this step
    @(posedge clk);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd, e);
  endtask : rchk
  // One host command; the monitor judges the answers it noted
  task automatic send(input uce0_tok_t k, input logic [3:0] ep, input logic [63:0] d,
    input logic [3:0] n, input logic bad, input logic [31:0] h);
    int i;
    if (h != NONE)
      hs_q.push_back(h);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_ep <= ep;
    cmd_data <= d;
    cmd_len <= n;
    cmd_bad <= bad;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (cmd_ready === 1'b1)
        break;
    end
    if (i == 50)
    begin
      failures++;
      results();
    end
    cmd_valid <= 1'b0;
    // Longest transfer here ends well inside this span
    repeat (24) @(posedge clk);
    check("answers left", hs_q.size() + byte_q.size(), 32'h0);
  endtask : send
  task automatic su(input logic [63:0] d);
    send(UCE0_TOK_SETUP, 4'h0, d, 4'd8, 1'b0, UCE0_HS_ACK);
  endtask : su
  // Compare each answer with the oldest note
  always @(posedge clk)
  begin
    if (rsp_valid === 1'b1)
      check("handshake", rsp_hs, hs_q.size() > 0 ? hs_q.pop_front() : NONE);
    if (rsp_bv === 1'b1)
    begin
      check("in byte", rsp_byte, byte_q.size() > 0 ? byte_q.pop_front() : 32'h100);
      check("in last", rsp_last, byte_q.size() == 0);
    end
  end
  initial
  begin
    logic [63:0] d;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check("fn addr", fn_addr, UCE0_FUNCTION_ADDRESS_REG_RST);
    apb(1'b1, UCE0_OFF_DBUF, 32'h5a96_c30f);
    seed = nxt(seed);
    d = {16'h0002, seed, 8'h06, 8'h80};
    su(d);
    rchk(UCE0_OFF_IRQ_REQ, 32'h3);
    check("irq", irq, 32'h0);
    rchk(UCE0_OFF_SETUP0, d[31:0]);
    rchk(UCE0_OFF_SETUP1, d[63:32]);
    rchk(UCE0_OFF_DBUF, 32'h5a96_c30f);
    rchk(UCE0_OFF_CS, 32'h2);
    apb(1'b1, UCE0_OFF_IRQ_REQ, 32'h0);
    rchk(UCE0_OFF_IRQ_REQ, 32'h3);
    apb(1'b1, UCE0_OFF_IRQ_REQ, 32'h3);
    rchk(UCE0_OFF_IRQ_REQ, 32'h0);
    apb(1'b1, UCE0_OFF_SUDPTR, 32'hffff_a5c3);
    rchk(UCE0_OFF_SUDPTR, 32'h0000_a5c3);
    apb(1'b0, 8'h30, 32'h0);
    check("slverr", perr, 32'h1);
    $display("test setup done");
    send(UCE0_TOK_IN, 4'h0, 64'h0, 4'd0, 1'b0, UCE0_HS_NAK);
    apb(1'b1, UCE0_OFF_BCNT, 32'h2);
    byte_q.push_back(32'h0f);
    byte_q.push_back(32'hc3);
    send(UCE0_TOK_IN, 4'h0, 64'h0, 4'd0, 1'b0, NONE);
    send(UCE0_TOK_OUT, 4'h0, 64'h0, 4'd0, 1'b0, UCE0_HS_NAK);
    apb(1'b1, UCE0_OFF_CS, 32'h0);
    rchk(UCE0_OFF_CS, 32'h2);
    apb(1'b1, UCE0_OFF_CS, 32'h2);
    rchk(UCE0_OFF_CS, 32'h0);
    send(UCE0_TOK_OUT, 4'h0, 64'h0, 4'd0, 1'b0, UCE0_HS_ACK);
    $display("test data and status done");
    apb(1'b1, UCE0_OFF_IRQ_EN, 32'h3);
    su(d);
    check("irq", irq, 32'h1);
    apb(1'b1, UCE0_OFF_CS, 32'h1);
    send(UCE0_TOK_IN, 4'h0, 64'h0, 4'd0, 1'b0, UCE0_HS_STALL);
    su(d);
    rchk(UCE0_OFF_CS, 32'h2);
    // Stall bit without the hold bit must not stall: an empty status packet comes back
    apb(1'b1, UCE0_OFF_CS, 32'h3);
    send(UCE0_TOK_IN, 4'h0, 64'h0, 4'd0, 1'b0, NONE);
    apb(1'b1, UCE0_OFF_IRQ_REQ, 32'h3);
    repeat (2) @(posedge clk);
    check("irq", irq, 32'h0);
    $display("test stall done");
    // Bad check value: token seen, data never reported
    send(UCE0_TOK_SETUP, 4'h0, d, 4'd8, 1'b1, NONE);
    rchk(UCE0_OFF_IRQ_REQ, 32'h1);
    apb(1'b1, UCE0_OFF_IRQ_REQ, 32'h3);
    send(UCE0_TOK_SETUP, 4'h1, d, 4'd8, 1'b0, NONE);
    rchk(UCE0_OFF_IRQ_REQ, 32'h0);
    $display("test refusals done");
    apb(1'b1, UCE0_OFF_CFG, 32'h1);
    seed = nxt(seed);
    su({32'h0, 8'h00, 1'b0, seed[6:0], 8'h05, 8'h00});
    rchk(UCE0_OFF_IRQ_REQ, 32'h1);
    apb(1'b1, UCE0_OFF_CS, 32'h2);
    send(UCE0_TOK_IN, 4'h0, 64'h0, 4'd0, 1'b0, NONE);
    check("fn addr", fn_addr, seed[6:0]);
    rchk(UCE0_OFF_FUNCTION_ADDRESS_REG, {25'h0, seed[6:0]});
    $display("test set address done");
    results();
  end
endmodule : tb
`default_nettype wire
